// ### logic/mode_if.sv
// mode_if: mode and rate settings shared with the helper modules
// assumes the register block drives every signal from flip-flops
interface mode_if;
    logic       spi_enable;  // module enabled
    logic       master_mode; // 1 master, 0 slave
    logic       fault_en;    // fault_detect_enable
    logic [1:0] rate_sel;    // rate_select_hi, rate_select_lo
    modport ctrl (output spi_enable, master_mode, fault_en, rate_sel);
    modport user (input  spi_enable, master_mode, fault_en, rate_sel);
endinterface : mode_if

// ### logic/rate_gen.sv
// rate_gen: master serial clock divider from the base clock
// assumes ref_clk is the base clock and run comes from the shifter
module rate_gen (
    input  wire logic ref_clk,
    input  wire logic resetn,
    mode_if.user      mode,
    input  wire logic run,
    output logic      sck,
    output logic      sck_edge
);
    logic [7:0] cnt_r, cnt_nxt;   // cycles into the half period
    logic       sck_r, sck_nxt;   // serial clock level
    logic       edg_r, edg_nxt;   // one-cycle toggle marker
    logic       active;           // divider running
    logic [7:0] half;             // half period in base cycles
    // next state: toggle every divisor cycles
    always_comb begin
        active  = mode.spi_enable & mode.master_mode & run; // [R13]
        half    = spi_regs_pkg::rate_div(mode.rate_sel);   // [R11]
        cnt_nxt = 8'h00;
        sck_nxt = 1'b0;
        edg_nxt = 1'b0;
        if (active) begin
            sck_nxt = sck_r;
            if (cnt_r == half - 8'h01) begin // [R12]
                sck_nxt = ~sck_r;
                edg_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end
    // state registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 8'h00;
            sck_r <= 1'b0;
            edg_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sck_r <= sck_nxt;
            edg_r <= edg_nxt;
        end
    end
    assign sck      = sck_r;
    assign sck_edge = edg_r;
endmodule : rate_gen

// ### logic/spi_regs_pkg.sv
// spi_regs_pkg: register offsets, field positions, reset values, rate table
// assumes a 32-bit apb bus with byte addresses and one clock, ref_clk
// Function
// R1: software writes data only while tx empty
// R2: data write clears the tx empty flag
// R3: tx empty set at reset, tracks buffer
// R4: mode fault sets only with detection enabled
// R5: disabling detection keeps a set fault
// R6: master without detection frees select pin
// R7: detection enabled makes select spi input
// R8: slave never frees the select pin; the code frees it to port logic while the module is disabled
// R9: master without detection ignores select level
// R10: slave without detection only masks faults
// R11: rate codes give divisors 2, 8, 32, 128
// R12: serial clock is base over twice divisor
// R13: rate field idle in slave, reset zero
// R14: data write loads only tx buffer
// R15: data read returns separate rx buffer
// R16: no read-modify-write on data register
// R17: tx load into shifter sets tx empty
// R18: tx empty with enable raises request
// R19: select edge sets fault per mode
// R20: fault clears by status read, control write
// R21: every access decodes, completes in one cycle
package spi_regs_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00; // serial_control_reg
    localparam logic [7:0] OFS_STAT   = 8'h04; // serial_status_control
    localparam logic [7:0] OFS_DATA   = 8'h08; // serial_data_buffer
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int C_TIE    = 0; // tx_empty_irq_enable
    localparam int C_ENA    = 1; // module enable
    localparam int C_MST    = 3; // master mode
    localparam int S_RLO    = 0; // rate_select_lo
    localparam int S_RHI    = 1; // rate_select_hi
    localparam int S_FEN    = 2; // fault_detect_enable
    localparam int S_TXE    = 3; // tx_empty_flag
    localparam int S_MODE_FAULT_FLAG   = 4; // mode_fault_flag
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic       RST_MST  = 1'b1;
    localparam logic       RST_TXE  = 1'b1;
    localparam logic [1:0] RST_RATE = 2'h0;
    // rate divisor for the two-bit select code
    function automatic logic [7:0] rate_div(input logic [1:0] sel);
        logic [7:0] d;
        d = 8'h02;
        unique case (sel)
            2'h0: d = 8'h02;
            2'h1: d = 8'h08;
            2'h2: d = 8'h20;
            2'h3: d = 8'h80;
        endcase
        return d;
    endfunction : rate_div
endpackage : spi_regs_pkg

// ### logic/spi_status_data_regs.sv
// spi_status_data_regs: apb registers, flags and pin control of the spi
// assumes a shifter on ref_clk takes tx_byte and delivers rx_byte
module spi_status_data_regs (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ss_pin,
    input  wire logic        xfer_active,
    input  wire logic        tx_load,
    input  wire logic        rx_strobe,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        sck_run,
    output logic      [7:0]  tx_byte,
    output logic             tx_full,
    output logic             tx_irq,
    output logic             mode_fault,
    output logic             ss_gpio_owned,
    output logic             ss_to_spi,
    output logic             spi_enable,
    output logic             master_mode,
    output logic             sck,
    output logic             sck_edge
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic        tie_r, tie_nxt;     // tx_empty_irq_enable
    logic        ena_r, ena_nxt;     // module enable
    logic        mst_r, mst_nxt;     // master mode
    logic        fen_r, fen_nxt;     // fault_detect_enable
    logic [1:0]  rate_r, rate_nxt;   // rate select field
    logic        txe_r, txe_nxt;     // tx_empty_flag
    logic        mode_fault_flag_r, mode_fault_flag_nxt;   // mode_fault_flag
    logic        arm_r, arm_nxt;     // status read seen with fault set
    logic [7:0]  txb_r, txb_nxt;     // transmit buffer
    logic [7:0]  rxb_r, rxb_nxt;     // receive buffer
    logic [31:0] rd_r, rd_nxt;       // read data held for access
    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic        setup;              // first apb cycle
    logic        access;             // second apb cycle
    logic        hit_ctrl;           // control address
    logic        hit_stat;           // status address
    logic        hit_data;           // data address
    logic        mapped;             // any register hit
    logic        wr_ctrl;            // control write taken
    logic        wr_stat;            // status write taken
    logic        wr_data;            // data write taken
    logic        rd_stat;            // status read taken
    // ---------------------------------------------------------------
    // pin and fault signals
    // ---------------------------------------------------------------
    logic        ss_level;           // filtered select level
    logic        ss_fall;            // select went low
    logic        ss_rise;            // select went high
    logic        gpio_owns;          // port logic owns the pin
    logic        fault_set;          // mode fault event
    logic        fault_clr;          // clearing sequence done
    mode_if      mode ();            // settings for helpers

    // apb phases and address match, one-cycle access
    always_comb begin
        setup    = psel & ~penable;
        access   = psel & penable;
        hit_ctrl = (paddr == spi_regs_pkg::OFS_CTRL);
        hit_stat = (paddr == spi_regs_pkg::OFS_STAT);
        hit_data = (paddr == spi_regs_pkg::OFS_DATA);
        mapped   = hit_ctrl | hit_stat | hit_data; // [R21]
        wr_ctrl  = access & pwrite & hit_ctrl;
        wr_stat  = access & pwrite & hit_stat;
        wr_data  = access & pwrite & hit_data;
        rd_stat  = access & ~pwrite & hit_stat;
    end

    // handshake: ready in every access, error on unmapped address
    assign pready  = access;            // [R21]
    assign pslverr = access & ~mapped;

    // ---------------------------------------------------------------
    // helper modules
    // ---------------------------------------------------------------
    assign mode.spi_enable  = ena_r;
    assign mode.master_mode = mst_r;
    assign mode.fault_en    = fen_r;
    assign mode.rate_sel    = rate_r;

    // select pin filter and ownership
    ss_ctrl u_ss (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .mode      (mode),
        .ss_pin    (ss_pin),
        .ss_level  (ss_level),
        .ss_fall   (ss_fall),
        .ss_rise   (ss_rise),
        .gpio_owns (gpio_owns)
    );

    // master clock divider
    rate_gen u_rate (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .mode     (mode),
        .run      (sck_run),
        .sck      (sck),
        .sck_edge (sck_edge)
    );

    // ---------------------------------------------------------------
    // fault detection
    // ---------------------------------------------------------------
    // master faults on any fall, slave on rise mid transfer
    always_comb begin
        fault_set = fen_r & ena_r                           // [R4] [R10]
                  & ((mst_r & ss_fall)
                  | (~mst_r & ss_rise & xfer_active));      // [R19]
        fault_clr = wr_ctrl & arm_r;                        // [R20]
    end

    // ---------------------------------------------------------------
    // register next values
    // ---------------------------------------------------------------
    always_comb begin
        tie_nxt  = tie_r;
        ena_nxt  = ena_r;
        mst_nxt  = mst_r;
        fen_nxt  = fen_r;
        rate_nxt = rate_r;
        txe_nxt  = txe_r;
        mode_fault_flag_nxt = mode_fault_flag_r;
        arm_nxt  = arm_r;
        txb_nxt  = txb_r;
        rxb_nxt  = rxb_r;
        rd_nxt   = rd_r;
        // control register write
        if (wr_ctrl) begin
            tie_nxt = pwdata[spi_regs_pkg::C_TIE];
            ena_nxt = pwdata[spi_regs_pkg::C_ENA];
            mst_nxt = pwdata[spi_regs_pkg::C_MST];
        end
        // status register write: only the writable bits change
        if (wr_stat) begin
            fen_nxt  = pwdata[spi_regs_pkg::S_FEN]; // [R5]
            rate_nxt = pwdata[spi_regs_pkg::S_RHI:spi_regs_pkg::S_RLO];
        end
        // data write fills the tx buffer only
        if (wr_data) begin
            txb_nxt = pwdata[7:0];                  // [R14]
            txe_nxt = 1'b0;                         // [R2]
        end
        // shifter took the byte: buffer empty again, set wins
        if (tx_load) begin
            txe_nxt = 1'b1;                         // [R17] [R3]
        end
        // receive buffer loads from the shifter only
        if (rx_strobe) begin
            rxb_nxt = rx_byte;                      // [R15]
        end
        // arm the fault clear on a status read with the flag set
        if (rd_stat & mode_fault_flag_r) begin
            arm_nxt = 1'b1;
        end
        // control write after the read clears flag and arm
        if (fault_clr) begin
            mode_fault_flag_nxt = 1'b0;                        // [R20]
            arm_nxt  = 1'b0;
        end
        // a new fault wins over the clear
        if (fault_set) begin
            mode_fault_flag_nxt = 1'b1;                        // [R4] [R19]
        end
        // read data is taken in setup and held through access
        if (setup) begin
            rd_nxt = 32'h0000_0000;
            if (hit_ctrl) begin
                rd_nxt[spi_regs_pkg::C_TIE] = tie_r;
                rd_nxt[spi_regs_pkg::C_ENA] = ena_r;
                rd_nxt[spi_regs_pkg::C_MST] = mst_r;
            end
            if (hit_stat) begin
                rd_nxt[spi_regs_pkg::S_RHI:spi_regs_pkg::S_RLO] = rate_r;
                rd_nxt[spi_regs_pkg::S_FEN]  = fen_r;
                rd_nxt[spi_regs_pkg::S_TXE]  = txe_r;  // [R3]
                rd_nxt[spi_regs_pkg::S_MODE_FAULT_FLAG] = mode_fault_flag_r;
            end
            if (hit_data) begin
                rd_nxt[7:0] = rxb_r;                   // [R15]
            end
        end
    end

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tie_r  <= 1'b0;
            ena_r  <= 1'b0;
            mst_r  <= spi_regs_pkg::RST_MST;
            fen_r  <= 1'b0;
            rate_r <= spi_regs_pkg::RST_RATE;       // [R13]
            txe_r  <= spi_regs_pkg::RST_TXE;        // [R3]
            mode_fault_flag_r <= 1'b0;
            arm_r  <= 1'b0;
            txb_r  <= 8'h00;
            rxb_r  <= 8'h00;
            rd_r   <= 32'h0000_0000;
        end else begin
            tie_r  <= tie_nxt;
            ena_r  <= ena_nxt;
            mst_r  <= mst_nxt;
            fen_r  <= fen_nxt;
            rate_r <= rate_nxt;
            txe_r  <= txe_nxt;
            mode_fault_flag_r <= mode_fault_flag_nxt;
            arm_r  <= arm_nxt;
            txb_r  <= txb_nxt;
            rxb_r  <= rxb_nxt;
            rd_r   <= rd_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata        = rd_r;
    assign tx_byte       = txb_r;
    assign tx_full       = ~txe_r;                  // [R3]
    assign tx_irq        = txe_r & tie_r;           // [R18]
    assign mode_fault    = mode_fault_flag_r;
    assign spi_enable    = ena_r;
    assign master_mode   = mst_r;
    assign ss_gpio_owned = gpio_owns;               // [R6] [R8]
    // spi sees the pin only when it owns it, else inactive high
    assign ss_to_spi     = gpio_owns | ss_level;    // [R7] [R9]

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    property p_tx_clear;
        wr_data && !tx_load |=> !txe_r && tx_full;
    endproperty
    a_tx_clear: assert property (p_tx_clear) // [R2]
        else $error("tx empty not cleared by data write");

    property p_tx_set;
        tx_load |=> txe_r ##0 !tx_full;
    endproperty
    a_tx_set: assert property (p_tx_set) // [R17]
        else $error("tx empty not set by shifter load");

    property p_tx_hold;
        !tx_load && !wr_data |=> $stable(txe_r);
    endproperty
    a_tx_hold: assert property (p_tx_hold) // [R3]
        else $error("tx empty changed without cause");

    property p_irq;
        $rose(txe_r) && tie_r |-> tx_irq;
    endproperty
    a_irq: assert property (p_irq) // [R18]
        else $error("tx request missing");

    property p_fault_gate;
        !fen_r && !mode_fault_flag_r |=> !mode_fault_flag_r;
    endproperty
    a_fault_gate: assert property (p_fault_gate) // [R4]
        else $error("mode fault set while detection off");

    property p_fault_keep;
        mode_fault_flag_r && !wr_ctrl |=> mode_fault_flag_r;
    endproperty
    a_fault_keep: assert property (p_fault_keep) // [R5]
        else $error("mode fault lost without clear");

    property p_fault_master;
        fen_r && ena_r && mst_r && ss_fall |=> mode_fault;
    endproperty
    a_fault_master: assert property (p_fault_master) // [R19]
        else $error("master fault not flagged");

    property p_fault_clear;
        rd_stat && mode_fault_flag_r ##1 (!fault_set && !wr_ctrl)[*2]
            ##1 wr_ctrl && !fault_set |=> !mode_fault_flag_r;
    endproperty
    a_fault_clear: assert property (p_fault_clear) // [R20]
        else $error("mode fault not cleared");

    property p_slave_pin;
        ena_r && !mst_r |-> !ss_gpio_owned && ss_to_spi == ss_level;
    endproperty
    a_slave_pin: assert property (p_slave_pin) // [R8]
        else $error("slave select freed in slave mode");

    property p_rx_keep;
        wr_data && !rx_strobe |=> $stable(rxb_r);
    endproperty
    a_rx_keep: assert property (p_rx_keep) // [R14]
        else $error("data write touched rx buffer");

    property p_rate2;
        sck_edge && sck_run && ena_r && mst_r && rate_r == 2'h0
            ##1 sck_run && ena_r && mst_r && rate_r == 2'h0
            |=> sck_edge;
    endproperty
    a_rate2: assert property (p_rate2) // [R12]
        else $error("divide by two period wrong");

    property p_ready;
        setup ##1 access |-> pready;
    endproperty
    a_ready: assert property (p_ready) // [R21]
        else $error("access not completed in one cycle");

    c_data_write: cover property (wr_data ##[1:20] tx_load);
    c_fault:      cover property ($rose(mode_fault_flag_r));
    c_fault_clr:  cover property ($fell(mode_fault_flag_r));
    c_sck:        cover property (sck_edge ##2 sck_edge);
endmodule : spi_status_data_regs

// ### logic/ss_ctrl.sv
// ss_ctrl: slave-select pin synchroniser, edges and pin ownership
// assumes ss_pin is an asynchronous pin level, active low
module ss_ctrl (
    input  wire logic ref_clk,
    input  wire logic resetn,
    mode_if.user      mode,
    input  wire logic ss_pin,
    output logic      ss_level,
    output logic      ss_fall,
    output logic      ss_rise,
    output logic      gpio_owns
);
    logic [2:0] sy_r, sy_nxt;   // three-stage synchroniser
    logic       lvl_r, lvl_nxt; // accepted level
    logic       fl_r, fl_nxt;   // falling edge pulse
    logic       rs_r, rs_nxt;   // rising edge pulse
    // next state: accept a change once stages two and three agree
    always_comb begin
        sy_nxt = {sy_r[1:0], ss_pin};
        lvl_nxt = (sy_r[1] == sy_r[2]) ? sy_r[2] : lvl_r;
        fl_nxt = lvl_r & ~lvl_nxt;
        rs_nxt = ~lvl_r & lvl_nxt;
    end
    // state registers, select idles high
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sy_r  <= 3'h7;
            lvl_r <= 1'b1;
            fl_r  <= 1'b0;
            rs_r  <= 1'b0;
        end else begin
            sy_r  <= sy_nxt;
            lvl_r <= lvl_nxt;
            fl_r  <= fl_nxt;
            rs_r  <= rs_nxt;
        end
    end
    assign ss_level = lvl_r;
    assign ss_fall  = fl_r;
    assign ss_rise  = rs_r;
    // port logic owns the pin when disabled or master without detection
    assign gpio_owns = ~mode.spi_enable
                     | (mode.master_mode & ~mode.fault_en); // [R6] [R7] [R8]
endmodule : ss_ctrl

// ### verif/spi_partner.sv
// spi_partner: shifter and remote serial device seen by the registers
// assumes the bench calls its tasks right after a rising clock edge
module spi_partner (
    input  wire logic       ref_clk,
    output logic            ss_pin,
    output logic            xfer_active,
    output logic            tx_load,
    output logic            rx_strobe,
    output logic [7:0]      rx_byte,
    output logic            sck_run
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // idle: select inactive, no transfer, divider stopped
    // ---------------------------------------------------------------
    initial begin
        ss_pin      = 1'b1;
        xfer_active = 1'b0;
        tx_load     = 1'b0;
        rx_strobe   = 1'b0;
        rx_byte     = 8'h00;
        sck_run     = 1'b0;
    end
    // one byte exchange: shifter takes tx buffer, hands back a byte
    task automatic swap(input logic [7:0] b);
        tx_load   <= 1'b1;
        rx_strobe <= 1'b1;
        rx_byte   <= b;
        @(posedge ref_clk);
        tx_load   <= 1'b0;
        rx_strobe <= 1'b0;
        rx_byte   <= ~b; // stale byte no longer shown
    endtask : swap
    // select level and transfer level of the far side
    task automatic sel(input logic lvl, input logic act);
        ss_pin      <= lvl;
        xfer_active <= act;
    endtask : sel
    // start or stop the master clock divider
    task automatic run(input logic r);
        sck_run <= r;
    endtask : run
endmodule : spi_partner

// ### verif/spi_status_data_regs_tb.sv
// spi_status_data_regs_tb: apb tests of flags, select pin, rates, data
// assumes spi_regs_pkg, the design and spi_partner are compiled first
module spi_status_data_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, rx_byte, tx_byte;
    logic [31:0] pwdata, prdata, rd;
    logic        ss_pin, xfer_active, tx_load, rx_strobe, sck_run, err;
    logic        tx_full, tx_irq, mode_fault, ss_gpio_owned, ss_to_spi;
    logic        spi_enable, master_mode, sck, sck_edge;
    int          num_errors, cmp_count, c;
    logic [7:0]  divs [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
    spi_status_data_regs i_spi_status_data_regs (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ss_pin(ss_pin), .xfer_active(xfer_active),
        .tx_load(tx_load), .rx_strobe(rx_strobe), .rx_byte(rx_byte),
        .sck_run(sck_run), .tx_byte(tx_byte), .tx_full(tx_full),
        .tx_irq(tx_irq), .mode_fault(mode_fault),
        .ss_gpio_owned(ss_gpio_owned), .ss_to_spi(ss_to_spi),
        .spi_enable(spi_enable), .master_mode(master_mode),
        .sck(sck), .sck_edge(sck_edge));
    spi_partner i_spi_partner (
        .ref_clk(ref_clk), .ss_pin(ss_pin), .xfer_active(xfer_active),
        .tx_load(tx_load), .rx_strobe(rx_strobe), .rx_byte(rx_byte),
        .sck_run(sck_run));
    // ---------------------------------------------------------------
    // clock, tasks
    // ---------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // compare and count
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask : check
    // one apb transfer, waits for pready at a rising edge, then one idle
    // edge so that a following transfer never re-drives psel at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdc
    // select pin changes pass a synchroniser: let them land
    task automatic settle();
        repeat (10) @(posedge ref_clk);
    endtask : settle
    // cycles between two sck_edge pulses
    task automatic gap(output int n);
        n = 0;
        while (sck_edge !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (sck_edge !== 1'b1 && n < 300);
    endtask : gap
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rdc(spi_regs_pkg::OFS_STAT, 32'h08);
        rdc(spi_regs_pkg::OFS_CTRL, 32'h08);
        $display("reset test done");
        // write data only while empty, never read-modify-write
        wr(spi_regs_pkg::OFS_CTRL, 32'h0b);
        @(posedge ref_clk);
        check(32'(tx_irq), 32'h1);
        wr(spi_regs_pkg::OFS_DATA, 32'ha5);
        @(posedge ref_clk);
        check(32'(tx_byte), 32'ha5);
        check(32'(tx_irq), 32'h0);
        check(32'(tx_full), 32'h1);
        rdc(spi_regs_pkg::OFS_STAT, 32'h00);
        i_spi_partner.swap(8'h5a);
        @(posedge ref_clk);
        rdc(spi_regs_pkg::OFS_STAT, 32'h08);
        rdc(spi_regs_pkg::OFS_DATA, 32'h5a);
        check(32'(tx_byte), 32'ha5);
        check(32'(tx_full), 32'h0);
        $display("data test done");
        // master: detection off, then on
        wr(spi_regs_pkg::OFS_CTRL, 32'h0a);
        i_spi_partner.sel(1'b0, 1'b0);
        settle();
        check(32'(ss_gpio_owned), 32'h1);
        check(32'(ss_to_spi), 32'h1);
        check(32'(mode_fault), 32'h0);
        i_spi_partner.sel(1'b1, 1'b0);
        wr(spi_regs_pkg::OFS_STAT, 32'h04);
        settle();
        check(32'(ss_gpio_owned), 32'h0);
        i_spi_partner.sel(1'b0, 1'b0);
        settle();
        check(32'(mode_fault), 32'h1);
        i_spi_partner.sel(1'b1, 1'b0);
        wr(spi_regs_pkg::OFS_STAT, 32'h00);
        wr(spi_regs_pkg::OFS_CTRL, 32'h0a);
        @(posedge ref_clk);
        check(32'(mode_fault), 32'h1);
        rdc(spi_regs_pkg::OFS_STAT, 32'h18);
        wr(spi_regs_pkg::OFS_CTRL, 32'h0a);
        @(posedge ref_clk);
        check(32'(mode_fault), 32'h0);
        $display("master fault test done");
        // slave: select rises during a transfer
        wr(spi_regs_pkg::OFS_CTRL, 32'h02);
        i_spi_partner.sel(1'b0, 1'b1);
        settle();
        check(32'(ss_gpio_owned), 32'h0);
        check(32'({spi_enable, master_mode}), 32'h2);
        i_spi_partner.sel(1'b1, 1'b1);
        settle();
        check(32'(mode_fault), 32'h0);
        wr(spi_regs_pkg::OFS_STAT, 32'h04);
        i_spi_partner.sel(1'b0, 1'b1);
        settle();
        i_spi_partner.sel(1'b1, 1'b1);
        settle();
        check(32'(mode_fault), 32'h1);
        i_spi_partner.sel(1'b1, 1'b0);
        rdc(spi_regs_pkg::OFS_STAT, 32'h1c);
        $display("slave fault test done");
        // master rates, one code at a time
        wr(spi_regs_pkg::OFS_CTRL, 32'h0a);
        for (int i = 0; i < 4; i++) begin
            wr(spi_regs_pkg::OFS_STAT, 32'(i));
            check(32'(sck), 32'h0);
            i_spi_partner.run(1'b1);
            gap(c);
            check(32'(c), 32'(divs[i]));
            i_spi_partner.run(1'b0);
            @(posedge ref_clk);
        end
        $display("rate test done");
        apb(1'b0, 8'h0c, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        $display("unmapped test done");
        print_verdict();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
endmodule : spi_status_data_regs_tb
